// *** afsp_regs.svh ***
// afsp_regs.svh: constants of the serial configuration port and powerdown control
// assumes: included by bare name from the package and both ends
//
// Functional notes
// [R1] host programs trim values by rate and gain
// [R2] master bit powers down clamp, buffers, amplifiers
// [R3] master bit overrides every other powerdown bit
// [R4] each block has its own powerdown bit
// [R5] serial clock stays below main clock, 20 MHz
// [R6] main clock runs during every transaction
// [R7] pins released while select is high
// [R8] host writes baseline values after power-up
// [R9] host lowers select, drives command from first edge
// [R10] write frame: 0, 0, address, data
// [R11] device samples input on rising serial edges
// [R12] output driven first eight clocks, rising edges
// [R13] output is register addressed by previous frame
// [R14] write takes effect when select rises
// [R15] read frame: 1, 0, address, ignored byte
// [R16] read takes two frames, select-high gap between
// [R17] host may send next command while reading
// [R18] read frame stages register, changes nothing
// [R19] clamp generator may stay off with external clamp
// [R20] short frame is discarded, registers untouched
`ifndef AFSP_REGS_SVH
`define AFSP_REGS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define AFSP_CLK_MHZ 125
`define AFSP_SCLK_PERIOD_NS 80
`define AFSP_SCLK_HALF ((`AFSP_SCLK_PERIOD_NS * `AFSP_CLK_MHZ) / 2000)
`define AFSP_SENW_NS 100
`define AFSP_SENW_CYC ((`AFSP_SENW_NS * `AFSP_CLK_MHZ + 999) / 1000)
// clk cycles from a host pin change until the device answer is driven on the output line
`define AFSP_LINK_LAT 3

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define AFSP_FRAME_BITS 16
`define AFSP_OUT_BITS 8
`define AFSP_DIR_BIT 15
`define AFSP_DEV_BIT 14
`define AFSP_ADDR_HI 13
`define AFSP_ADDR_LO 8
`define AFSP_DIR_WRITE 1'b0
`define AFSP_DIR_READ 1'b1
`define AFSP_DEV_ADDR 1'b0

// ----------------------------------------------------------------
// device registers
// ----------------------------------------------------------------
`define AFSP_REG_PWR_OFF 6'h01
`define AFSP_REG_RESET 8'h00
`define AFSP_PD_MASTER 7
`define AFSP_PD_CLAMP 6
`define AFSP_PD_REF_HI 5
`define AFSP_PD_REF_LO 4
`define AFSP_PD_PGA_HI 3
`define AFSP_PD_PGA_LO 2
`define AFSP_PD_ADC_HI 1
`define AFSP_PD_ADC_LO 0
`define AFSP_TRIM_PGA_FAST 8'h09
`define AFSP_TRIM_ADC_FAST 8'h08
`define AFSP_TRIM_PGA_SLOW 8'h01

// ----------------------------------------------------------------
// host wishbone map
// ----------------------------------------------------------------
`define AFSP_WB_CMD 4'h0
`define AFSP_WB_STAT 4'h4
`define AFSP_WB_DIV 4'h8
`define AFSP_STAT_BUSY 0
`define AFSP_STAT_RX_LO 8

`endif

// *** afsp_pkg.sv ***
// afsp_pkg.sv: types shared by both ends of the serial configuration port
// assumes: afsp_regs.svh on the include path
`include "afsp_regs.svh"

package afsp_pkg;
	typedef logic [7:0] afsp_byte_type;
	typedef logic [5:0] afsp_addr_type;
	typedef logic [15:0] afsp_frame_type;
	// gray along idle, lead, shift, tail, gap
	typedef enum logic [2:0] {
		AFSP_IDLE = 3'h0,
		AFSP_LEAD = 3'h1,
		AFSP_SHIFT = 3'h3,
		AFSP_TAIL = 3'h2,
		AFSP_GAP = 3'h6
	} afsp_state_type;
endpackage

// *** afsp_if.sv ***
// afsp_if.sv: four-wire serial link between host and device
// assumes: the serial output line idles high when nobody drives it
interface afsp_if;
	logic sclk; // serial clock from host
	logic senN; // frame select, active low
	logic serial_in_pin; // host to device data
	logic sdoOut; // device output value
	logic sdoOe; // device output enable
	logic serial_out_pin; // resolved output line

	// pull-up stands in for the released line
	assign serial_out_pin = sdoOe ? sdoOut : 1'b1;

	modport dev (input sclk, input senN, input serial_in_pin, output sdoOut, output sdoOe);
	modport host (output sclk, output senN, output serial_in_pin, input serial_out_pin);
endinterface // afsp_if

// *** afsp_sync.sv ***
// afsp_sync.sv: two flip-flop synchroniser for slow link pins
// assumes: inputs are levels that stay put for several clocks
module afsp_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic [WIDTH-1:0] din, // asynchronous inputs
	output logic [WIDTH-1:0] dout // synchronised outputs
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] stable_r;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_r <= RST_VAL;
			stable_r <= RST_VAL;
		end else begin
			meta_r <= din;
			stable_r <= meta_r;
		end
	end

	assign dout = stable_r;
endmodule // afsp_sync

// *** afsp_device.sv ***
// afsp_device.sv: device end, serial register file and powerdown control
// assumes: clk is the main clock and runs through every frame; sclk is slow
// enough to be oversampled several times per half period
`include "afsp_regs.svh"

module afsp_device (
	input wire logic clk, // main clock
	input wire logic nrst, // async reset, active low
	afsp_if.dev link, // serial link pins
	output logic clampOff, // clamp generator powered down
	output logic [1:0] refBufOff, // reference buffers off, bit1 = ch2
	output logic [1:0] pgaOff, // amplifiers off, bit1 = ch2
	output logic [1:0] adcOff, // converter amplifiers off, bit1 = ch2
	output logic cfgWrStb, // one-cycle pulse per register write
	output afsp_pkg::afsp_addr_type cfgWrAddr, // address of last write
	output afsp_pkg::afsp_byte_type cfgWrData, // value of last write
	output logic frameDropStb // one-cycle pulse, frame discarded
);
	import afsp_pkg::*;

	localparam int ADDR_W = 6;
	localparam int NUM_REGS = 2 ** ADDR_W;
	localparam logic [4:0] FULL_CNT = 5'(`AFSP_FRAME_BITS);
	localparam logic [4:0] LAST_OUT = 5'(`AFSP_OUT_BITS - 1);
	localparam logic [4:0] SAT_CNT = 5'h1F;

	// ----------------------------------------------------------------
	// pin capture
	// ----------------------------------------------------------------
	logic sclkS;
	logic senNS;
	logic sdiS;
	logic sclkD_r;
	logic senND_r;

	// select resets high so no frame is seen during reset
	afsp_sync #(
		.WIDTH(3),
		.RST_VAL(3'h2)
	) uSync (
		.clk(clk),
		.nrst(nrst),
		.din({link.sclk, link.senN, link.serial_in_pin}),
		.dout({sclkS, senNS, sdiS})
	);

	// delayed copies for edge finding
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sclkD_r <= 1'b0;
			senND_r <= 1'b1;
		end else begin
			sclkD_r <= sclkS;
			senND_r <= senNS;
		end
	end

	// ----------------------------------------------------------------
	// edge and frame decode
	// ----------------------------------------------------------------
	wire inFrame;
	wire sclkRise;
	wire frameStart;
	wire frameEnd;

	assign inFrame = ~senNS;
	assign sclkRise = sclkS & ~sclkD_r;
	assign frameStart = senND_r & ~senNS;
	assign frameEnd = ~senND_r & senNS;

	// ----------------------------------------------------------------
	// input shifter
	// ----------------------------------------------------------------
	afsp_frame_type shiftIn_r;
	logic [4:0] bitCnt_r;

	// sample on each rising serial edge inside a frame [R11]
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			shiftIn_r <= '0;
		end else if (inFrame && sclkRise) begin
			shiftIn_r <= {shiftIn_r[`AFSP_FRAME_BITS-2:0], sdiS}; // [R11]
		end
	end

	// count saturates so overlong frames never wrap back to a valid count
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bitCnt_r <= '0;
		end else if (frameStart) begin
			bitCnt_r <= '0;
		end else if (inFrame && sclkRise && bitCnt_r != SAT_CNT) begin
			bitCnt_r <= bitCnt_r + 5'h01;
		end
	end

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	wire frameOk;
	wire isWrite;
	wire addressed;
	wire frameTake;
	wire doWrite;
	wire frameDrop;
	afsp_addr_type frameAddr;
	afsp_byte_type frameData;
	afsp_byte_type regsRd;
	afsp_byte_type stageNxt;

	assign frameAddr = shiftIn_r[`AFSP_ADDR_HI:`AFSP_ADDR_LO];
	assign frameData = shiftIn_r[`AFSP_OUT_BITS-1:0];
	assign frameOk = (bitCnt_r == FULL_CNT); // [R20]
	assign isWrite = (shiftIn_r[`AFSP_DIR_BIT] == `AFSP_DIR_WRITE); // [R10] [R15]
	assign addressed = (shiftIn_r[`AFSP_DEV_BIT] == `AFSP_DEV_ADDR); // [R10] [R15]
	assign frameTake = frameEnd & frameOk & addressed;
	assign doWrite = frameTake & isWrite; // [R14]
	assign frameDrop = frameEnd & ~frameOk; // [R20]

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	afsp_byte_type regs_r [NUM_REGS];

	// written only at select rise of a complete write frame [R14] [R20]
	for (genvar i = 0; i < NUM_REGS; i++) begin : gReg
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				regs_r[i] <= `AFSP_REG_RESET;
			end else if (doWrite && frameAddr == ADDR_W'(i)) begin
				regs_r[i] <= frameData; // [R14]
			end
		end
	end

	// read frames leave the file alone and stage the current value
	assign regsRd = regs_r[frameAddr];
	assign stageNxt = isWrite ? frameData : regsRd; // [R13] [R18]

	// ----------------------------------------------------------------
	// output staging and shifter
	// ----------------------------------------------------------------
	afsp_byte_type staged_r;
	afsp_byte_type outSh_r;
	logic sdoOut_r;
	logic sdoOe_r;

	// staged byte is what the next frame returns [R13] [R18]
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			staged_r <= `AFSP_REG_RESET;
		end else if (frameTake) begin
			staged_r <= stageNxt; // [R13] [R18]
		end
	end

	// msb leads at select fall, later bits move on rising edges [R12]
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			outSh_r <= '0;
			sdoOut_r <= 1'b0;
			sdoOe_r <= 1'b0;
		end else if (!inFrame) begin
			sdoOe_r <= 1'b0; // [R7]
		end else if (frameStart) begin
			outSh_r <= staged_r;
			sdoOut_r <= staged_r[`AFSP_OUT_BITS-1]; // [R13]
			sdoOe_r <= 1'b1; // [R12]
		end else if (sclkRise && bitCnt_r == LAST_OUT) begin
			sdoOe_r <= 1'b0; // [R12]
		end else if (sclkRise && bitCnt_r < LAST_OUT) begin
			outSh_r <= {outSh_r[`AFSP_OUT_BITS-2:0], 1'b0};
			sdoOut_r <= outSh_r[`AFSP_OUT_BITS-2]; // [R12]
		end
	end

	assign link.sdoOut = sdoOut_r;
	assign link.sdoOe = sdoOe_r; // [R7]

	// ----------------------------------------------------------------
	// powerdown control
	// ----------------------------------------------------------------
	afsp_byte_type pwrReg;
	wire master;
	logic clampOff_r;
	logic [1:0] refBufOff_r;
	logic [1:0] pgaOff_r;
	logic [1:0] adcOff_r;

	assign pwrReg = regs_r[`AFSP_REG_PWR_OFF];
	assign master = pwrReg[`AFSP_PD_MASTER];

	// master bit ors into every block, so no other bit can keep one alive
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			clampOff_r <= 1'b0;
			refBufOff_r <= '0;
			pgaOff_r <= '0;
			adcOff_r <= '0;
		end else begin
			clampOff_r <= master | pwrReg[`AFSP_PD_CLAMP]; // [R2] [R3] [R4] [R19]
			refBufOff_r <= {2{master}} | pwrReg[`AFSP_PD_REF_HI:`AFSP_PD_REF_LO]; // [R2] [R4]
			pgaOff_r <= {2{master}} | pwrReg[`AFSP_PD_PGA_HI:`AFSP_PD_PGA_LO]; // [R2] [R3]
			adcOff_r <= {2{master}} | pwrReg[`AFSP_PD_ADC_HI:`AFSP_PD_ADC_LO]; // [R2] [R4]
		end
	end

	assign clampOff = clampOff_r;
	assign refBufOff = refBufOff_r;
	assign pgaOff = pgaOff_r;
	assign adcOff = adcOff_r;

	// ----------------------------------------------------------------
	// user-side write report
	// ----------------------------------------------------------------
	logic cfgWrStb_r;
	afsp_addr_type cfgWrAddr_r;
	afsp_byte_type cfgWrData_r;
	logic frameDrop_r;

	// lets the analog model pick up new settings from the write onward
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfgWrStb_r <= 1'b0;
			cfgWrAddr_r <= '0;
			cfgWrData_r <= '0;
			frameDrop_r <= 1'b0;
		end else begin
			cfgWrStb_r <= doWrite; // [R14]
			frameDrop_r <= frameDrop; // [R20]
			if (doWrite) begin
				cfgWrAddr_r <= frameAddr;
				cfgWrData_r <= frameData;
			end
		end
	end

	assign cfgWrStb = cfgWrStb_r;
	assign cfgWrAddr = cfgWrAddr_r;
	assign cfgWrData = cfgWrData_r;
	assign frameDropStb = frameDrop_r;
endmodule // afsp_device

// *** afsp_host.sv ***
// afsp_host.sv: host end, wishbone slave that runs serial frames
// assumes: software writes baselines and trims through the command register;
// device main clock runs whenever a frame is issued
`include "afsp_regs.svh"

module afsp_host (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [3:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte enables
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	afsp_if.host link // serial link pins
);
	import afsp_pkg::*;

	// ----------------------------------------------------------------
	// wishbone decode
	// ----------------------------------------------------------------
	afsp_state_type state_r;
	afsp_frame_type cmd_r;
	afsp_frame_type cmdNxt;
	afsp_byte_type div_r;
	afsp_byte_type rx_r;
	logic ack_r;
	logic [31:0] datO_r;
	logic [31:0] rdData;
	wire wbReq;
	wire selCmd;
	wire selStat;
	wire selDiv;
	wire start;
	wire busy;

	assign wbReq = wb_cyc_i & wb_stb_i & ~ack_r;
	assign selCmd = (wb_adr_i == `AFSP_WB_CMD);
	assign selStat = (wb_adr_i == `AFSP_WB_STAT);
	assign selDiv = (wb_adr_i == `AFSP_WB_DIV);
	assign busy = (state_r != AFSP_IDLE);
	// commands while busy are dropped; software polls busy first
	assign start = wbReq & wb_we_i & selCmd & ~busy; // [R1] [R8]

	// byte lanes merge into the command word
	for (genvar b = 0; b < 2; b++) begin : gLane
		assign cmdNxt[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8] : cmd_r[b*8 +: 8];
	end

	// device address bit is forced so frames always hit the device [R10] [R15]
	wire [15:0] frameNxt;
	assign frameNxt = {cmdNxt[`AFSP_DIR_BIT], `AFSP_DEV_ADDR, cmdNxt[`AFSP_DEV_BIT-1:0]};

	// unmapped addresses read as zero and still acknowledge
	assign rdData = selCmd ? {16'h0000, cmd_r} :
		selStat ? {16'h0000, rx_r, 7'h00, busy} :
		selDiv ? {24'h000000, div_r} : 32'h00000000;

	// single-wait-state slave
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack_r <= 1'b0;
			datO_r <= '0;
			cmd_r <= '0;
			div_r <= 8'(`AFSP_SCLK_HALF);
		end else begin
			ack_r <= wbReq;
			if (wbReq) datO_r <= rdData;
			if (start) cmd_r <= frameNxt;
			if (wbReq && wb_we_i && selDiv && wb_sel_i[0]) div_r <= wb_dat_i[7:0]; // [R5]
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = datO_r;

	// ----------------------------------------------------------------
	// serial engine
	// ----------------------------------------------------------------
	logic sdoS;
	logic sclk_r;
	logic senN_r;
	logic sdi_r;
	afsp_frame_type shOut_r;
	logic [7:0] cnt_r;
	logic [4:0] bitIdx_r;
	wire cntDone;

	afsp_sync #(
		.WIDTH(1),
		.RST_VAL(1'b1)
	) uSdoSync (
		.clk(clk),
		.nrst(nrst),
		.din(link.serial_out_pin),
		.dout(sdoS)
	);

	assign cntDone = (cnt_r <= 8'h01);

	// sclk is a divider of clk; half period set by the divider register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= AFSP_IDLE;
			sclk_r <= 1'b0;
			senN_r <= 1'b1;
			sdi_r <= 1'b0;
			shOut_r <= '0;
			cnt_r <= '0;
			bitIdx_r <= '0;
			rx_r <= '0;
		end else begin
			cnt_r <= cntDone ? div_r : cnt_r - 8'h01;
			case (state_r)
				AFSP_IDLE: begin
					// lead spans the synchroniser round trip so the first returned bit
					// has settled; limitation: dividers above 252 wrap the lead count
					cnt_r <= div_r + 8'(`AFSP_LINK_LAT); // [R12] [R13]
					if (start) begin
						senN_r <= 1'b0; // [R9]
						shOut_r <= frameNxt;
						sdi_r <= frameNxt[`AFSP_DIR_BIT]; // [R9] [R17]
						state_r <= AFSP_LEAD;
					end
				end
				AFSP_LEAD: if (cntDone) begin
					sclk_r <= 1'b1;
					bitIdx_r <= '0;
					rx_r <= {rx_r[6:0], sdoS}; // [R13] [R16]
					state_r <= AFSP_SHIFT;
				end
				AFSP_SHIFT: if (cntDone) begin
					sclk_r <= ~sclk_r;
					if (sclk_r) begin
						bitIdx_r <= bitIdx_r + 5'h01;
						shOut_r <= {shOut_r[14:0], 1'b0};
						sdi_r <= shOut_r[14];
						if (bitIdx_r == 5'(`AFSP_FRAME_BITS - 1)) state_r <= AFSP_TAIL;
					end else if (bitIdx_r < 5'(`AFSP_OUT_BITS)) begin
						rx_r <= {rx_r[6:0], sdoS};
					end
				end
				AFSP_TAIL: if (cntDone) begin
					senN_r <= 1'b1; // [R14]
					cnt_r <= 8'(`AFSP_SENW_CYC);
					state_r <= AFSP_GAP;
				end
				AFSP_GAP: if (cntDone) begin
					state_r <= AFSP_IDLE; // [R16]
				end
				default: state_r <= AFSP_IDLE;
			endcase
		end
	end

	assign link.sclk = sclk_r; // [R5] [R6]
	assign link.senN = senN_r;
	assign link.serial_in_pin = sdi_r;
endmodule // afsp_host

// *** afsp_link_sva.sv ***
// afsp_link_sva.sv: checks on the four-wire link between host and device
// assumes: instanced beside the interface, clk and nrst of the system domain
module afsp_link_sva (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic sclk, // serial clock
	input wire logic senN, // frame select, active low
	input wire logic serial_in_pin, // host to device data
	input wire logic sdoOe, // device output enable
	input wire logic serial_out_pin // resolved output line
);
	// ----------------------------------------------------------------
	// helper counters
	// ----------------------------------------------------------------
	logic sclkDly_r;
	logic [4:0] riseCnt_r;
	logic [3:0] sinceRise_r;
	wire logic sclkRise = sclk && !sclkDly_r;

	// rises seen in this frame; cleared while select is high
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sclkDly_r <= 1'b0;
			riseCnt_r <= 5'h00;
		end else begin
			sclkDly_r <= sclk;
			riseCnt_r <= senN ? 5'h00 : riseCnt_r + 5'(sclkRise);
		end
	end

	// cycles since the last rise, saturating so old rises look far away
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sinceRise_r <= 4'hF;
		end else begin
			sinceRise_r <= sclkRise ? 4'h0 : sinceRise_r + 4'(sinceRise_r != 4'hF);
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	a_oe_quiet_idle: assert property (senN [*4] |-> !sdoOe)
		else $error("output enabled while deselected");
	a_oe_frame_start: assert property ($rose(sdoOe) |-> !senN && riseCnt_r == 5'h00)
		else $error("output enabled outside frame start");
	a_oe_on_time: assert property ($fell(senN) |-> ##[1:6] sdoOe)
		else $error("output not enabled after select fell");
	a_oe_eight_rises: assert property (riseCnt_r == 5'h08 && sinceRise_r == 4'h6 |-> !sdoOe)
		else $error("output still driven after eighth rise");
	a_oe_bounded: assert property (sdoOe |-> riseCnt_r <= 5'h08)
		else $error("output driven past eight clocks");
	a_bit_moves_rise: assert property (sdoOe && $past(sdoOe) && $changed(serial_out_pin) |-> sinceRise_r <= 4'h5)
		else $error("output bit changed away from a rise");
	a_frame_sixteen: assert property ($rose(senN) |-> riseCnt_r == 5'h10)
		else $error("frame closed without sixteen rises");
	a_dev_bit_zero: assert property (sclkRise && riseCnt_r == 5'h01 |-> !serial_in_pin)
		else $error("device address bit not zero");
	a_sdi_steady_high: assert property (sclk && $past(sclk) |-> $stable(serial_in_pin))
		else $error("input moved while clock high");
	a_sclk_idle_low: assert property (senN |-> !sclk)
		else $error("serial clock high while deselected");
	a_lead_time: assert property ($fell(senN) |-> !sclk [*4])
		else $error("first rise too soon after select");
	a_gap_high: assert property ($rose(senN) |-> senN [*8])
		else $error("select high gap too short");
endmodule // afsp_link_sva

// *** afe_serial_config_and_powerdown_bench.sv ***
// afe_serial_config_and_powerdown_bench.sv: host and device joined, plus a bench-driven device
// assumes: afsp_pkg and afsp_regs.svh compiled first; 125 MHz clock
`include "afsp_regs.svh"
module afe_serial_config_and_powerdown_bench import afsp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, wbCyc, wbStb, wbWe, wbAck, wrStb, wrStbB, dropStbB;
	logic [3:0] wbAdr, wbSel;
	logic [31:0] wbDatI, wbDatO;
	logic [6:0] pwr, pwrB;
	afsp_addr_type wrAddr;
	afsp_byte_type wrData;
	int num_errors, samples_checked, wrCount, wrCountB, dropCountB, cycles;
	afsp_if link();
	afsp_if linkB();

	afsp_host afsp_host_inst (.clk(clk), .nrst(nrst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
		.wb_dat_o(wbDatO), .wb_ack_o(wbAck), .link(link));
	afsp_device afsp_device_inst (.clk(clk), .nrst(nrst), .link(link), .clampOff(pwr[6]),
		.refBufOff(pwr[5:4]), .pgaOff(pwr[3:2]), .adcOff(pwr[1:0]), .cfgWrStb(wrStb),
		.cfgWrAddr(wrAddr), .cfgWrData(wrData), .frameDropStb());
	// second device faces the bench so broken frames can be sent
	afsp_device afsp_device_inst_b (.clk(clk), .nrst(nrst), .link(linkB), .clampOff(pwrB[6]),
		.refBufOff(pwrB[5:4]), .pgaOff(pwrB[3:2]), .adcOff(pwrB[1:0]), .cfgWrStb(wrStbB),
		.cfgWrAddr(), .cfgWrData(), .frameDropStb(dropStbB));
	afsp_link_sva afsp_link_sva_inst (.clk(clk), .nrst(nrst), .sclk(link.sclk),
		.senN(link.senN), .serial_in_pin(link.serial_in_pin), .sdoOe(link.sdoOe), .serial_out_pin(link.serial_out_pin));

	// clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// pulse counters and hang guard
	always @(posedge clk) begin
		wrCount += int'(wrStb === 1'b1);
		wrCountB += int'(wrStbB === 1'b1);
		dropCountB += int'(dropStbB === 1'b1);
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			stop_test();
		end
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test;
		$display("checked %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask

	function automatic logic [15:0] mkCmd(input logic dir, input afsp_addr_type a,
		input afsp_byte_type d);
		return {dir, `AFSP_DEV_ADDR, a, d};
	endfunction

	// classic cycle: held until ack is sampled, then released for a cycle
	task automatic wbCycle(input logic we, input logic [3:0] adr, input logic [31:0] dat,
		output logic [31:0] rd);
		int n;
		@(posedge clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbDatI <= dat;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wbAck !== 1'b1 && n < 50);
		rd = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		check(32'(n < 50), 32'h1, "ack wait");
		if (n >= 50) begin
			stop_test();
		end
	endtask

	task automatic waitIdle(output logic [31:0] rd);
		int n;
		n = 0;
		do begin
			wbCycle(1'b0, `AFSP_WB_STAT, 32'h0, rd);
			n++;
		end while (rd[`AFSP_STAT_BUSY] !== 1'b0 && n < 200);
		check(32'(n < 200), 32'h1, "busy wait");
		if (n >= 200) begin
			stop_test();
		end
		repeat (4) @(posedge clk);
	endtask

	task automatic frame(input logic [15:0] cmd, output afsp_byte_type rx);
		logic [31:0] rd;
		waitIdle(rd);
		wbCycle(1'b1, `AFSP_WB_CMD, {16'h0000, cmd}, rd);
		waitIdle(rd);
		rx = rd[15:8];
	endtask

	// bench as host on the second link; n rises, then select up
	task automatic sendB(input logic [15:0] v, input int n);
		int i;
		@(posedge clk);
		linkB.senN <= 1'b0;
		linkB.serial_in_pin <= v[15];
		repeat (5) @(posedge clk);
		for (i = 0; i < n; i++) begin
			linkB.sclk <= 1'b1;
			repeat (5) @(posedge clk);
			linkB.sclk <= 1'b0;
			linkB.serial_in_pin <= (i < 15) ? v[14 - i] : ~v[0];
			repeat (5) @(posedge clk);
		end
		linkB.senN <= 1'b1;
		repeat (20) @(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic testReset;
		logic [31:0] rd;
		check({25'h0, pwr}, 32'h0, "power at reset");
		wbCycle(1'b0, `AFSP_WB_DIV, 32'h0, rd);
		check(rd, 32'(`AFSP_SCLK_HALF), "divider reset");
		wbCycle(1'b1, `AFSP_WB_DIV, 32'h7, rd);
		wbCycle(1'b0, `AFSP_WB_DIV, 32'h0, rd);
		check(rd, 32'h7, "divider written");
		wbCycle(1'b1, `AFSP_WB_DIV, 32'(`AFSP_SCLK_HALF), rd);
		wbCycle(1'b0, 4'hC, 32'h0, rd);
		check(rd, 32'h0, "unmapped read");
		$display("test reset done");
	endtask

	task automatic testWrite;
		afsp_byte_type rx;
		frame(mkCmd(`AFSP_DIR_WRITE, `AFSP_REG_PWR_OFF, 8'h15), rx);
		check({24'h0, rx}, 32'h0, "first staged byte");
		check({25'h0, pwr}, 32'h15, "single blocks off");
		check({18'h0, wrAddr, wrData}, {18'h0, 6'h01, 8'h15}, "write report");
		frame(mkCmd(`AFSP_DIR_WRITE, `AFSP_REG_PWR_OFF, 8'h6A), rx);
		check({24'h0, rx}, 32'h15, "written byte staged");
		check({25'h0, pwr}, 32'h6A, "other channel off");
		$display("test write done");
	endtask

	task automatic testMaster;
		afsp_byte_type rx;
		frame(mkCmd(`AFSP_DIR_WRITE, `AFSP_REG_PWR_OFF, 8'hA5), rx);
		check({24'h0, rx}, 32'h6A, "staged byte");
		check({25'h0, pwr}, 32'h7F, "master over mixed bits");
		frame(mkCmd(`AFSP_DIR_WRITE, `AFSP_REG_PWR_OFF, 8'h80), rx);
		check({25'h0, pwr}, 32'h7F, "master alone");
		frame(mkCmd(`AFSP_DIR_WRITE, `AFSP_REG_PWR_OFF, 8'h00), rx);
		check({25'h0, pwr}, 32'h0, "all back on");
		$display("test master done");
	endtask

	task automatic testRead;
		afsp_byte_type rx;
		int w0;
		frame(mkCmd(`AFSP_DIR_WRITE, 6'h02, `AFSP_TRIM_PGA_FAST), rx);
		frame(mkCmd(`AFSP_DIR_WRITE, 6'h03, `AFSP_TRIM_ADC_FAST), rx);
		w0 = wrCount;
		frame(mkCmd(`AFSP_DIR_READ, 6'h02, 8'hFF), rx);
		check({24'h0, rx}, 32'h08, "previous write staged");
		frame(mkCmd(`AFSP_DIR_READ, 6'h01, 8'h5A), rx);
		check({24'h0, rx}, 32'h09, "second frame of read");
		frame(mkCmd(`AFSP_DIR_READ, 6'h03, 8'h00), rx);
		check({24'h0, rx}, 32'h00, "read staged register");
		check(32'(wrCount - w0), 32'h0, "reads write nothing");
		check({25'h0, pwr}, 32'h0, "power kept on read");
		$display("test read done");
	endtask

	task automatic testBusy;
		logic [31:0] rd;
		afsp_byte_type rx;
		wbCycle(1'b1, `AFSP_WB_CMD, {16'h0, mkCmd(`AFSP_DIR_WRITE, 6'h01, 8'h03)}, rd);
		// second command lands while busy and must be dropped
		wbCycle(1'b1, `AFSP_WB_CMD, {16'h0, mkCmd(`AFSP_DIR_WRITE, 6'h01, 8'h7C)}, rd);
		waitIdle(rd);
		check({25'h0, pwr}, 32'h03, "busy command dropped");
		wbCycle(1'b0, `AFSP_WB_CMD, 32'h0, rd);
		check(rd, {16'h0, mkCmd(`AFSP_DIR_WRITE, 6'h01, 8'h03)}, "command kept");
		frame(mkCmd(`AFSP_DIR_READ, 6'h01, 8'h00), rx);
		check({24'h0, rx}, 32'h03, "staged after write");
		$display("test busy done");
	endtask

	task automatic testShort;
		int d0;
		int w0;
		d0 = dropCountB;
		w0 = wrCountB;
		sendB(mkCmd(`AFSP_DIR_WRITE, 6'h01, 8'h42), 16);
		check({25'h0, pwrB}, 32'h42, "bench frame written");
		sendB(mkCmd(`AFSP_DIR_WRITE, 6'h01, 8'h7F), 12);
		sendB(mkCmd(`AFSP_DIR_WRITE, 6'h01, 8'h7F), 15);
		check({25'h0, pwrB}, 32'h42, "short frames ignored");
		check(32'(dropCountB - d0), 32'h2, "drops reported");
		check(32'(wrCountB - w0), 32'h1, "one write only");
		$display("test short done");
	endtask

	// reset for four cycles, then the scenarios in turn
	initial begin
		num_errors = 0;
		samples_checked = 0;
		wrCount = 0;
		wrCountB = 0;
		dropCountB = 0;
		cycles = 0;
		nrst = 1'b0;
		wbCyc = 1'b0;
		wbStb = 1'b0;
		wbWe = 1'b0;
		wbAdr = 4'h0;
		wbSel = 4'hF;
		wbDatI = 32'h0;
		linkB.sclk = 1'b0;
		linkB.senN = 1'b1;
		linkB.serial_in_pin = 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		testReset();
		testWrite();
		testMaster();
		testRead();
		testBusy();
		testShort();
		stop_test();
	end
endmodule // afe_serial_config_and_powerdown_bench
